// file: rtl/tap_port.sv
// Four-pin serial test access port: state machine, IR, DR and data output.
// Assumes TCK/TMS/TDI arrive asynchronously to I_MCLK, and pad pulls sit outside.
`timescale 1ns/1ps
// Contract
// - Test clock times all shifting; pad pulls hold TCK low, TMS and TDI high
// - Mode select sampled on rising test clock
// - Data input captured on rising test clock
// - Data output changes on falling edges only
// - Data output driven from a falling edge in a shift state to the next falling edge outside one
// - Data output tri-stated while device reset
module tap_port import tap_pkg::*; (
    input  logic              I_MCLK,
    input  logic              I_NRST,
    input  logic              I_TCK,
    input  logic              I_TMS,
    input  logic              I_TDI,
    output logic              O_TDO,
    output logic              O_TDO_OE,
    output logic [IR_W-1:0]   O_IR,
    output logic [3:0]        O_TAP_STATE,
    input  logic              I_TX_VALID,
    input  logic [DATA_W-1:0] I_TX_DATA,
    output logic              O_TX_READY,
    output logic              O_RX_VALID,
    output logic [DATA_W-1:0] O_RX_DATA,
    input  logic              I_RX_READY,
    output logic              O_RX_SPACE,
    output logic              O_RX_DROP
);

    typedef struct packed {
        pins_s             meta;
        pins_s             sync;
        logic              tck_prev;
        tap_state_e        state;
        logic [IR_W-1:0]   ir_sh;
        logic [IR_W-1:0]   ir;
        logic [DATA_W-1:0] dr;
        logic              tdo;
        logic              tdo_oe;
        logic              drop;
    } port_s;

    port_s q;
    port_s d;
    logic  rise;
    logic  fall;
    logic  push;
    logic  fifo_ready;
    word_s rx_out;

    function automatic tap_state_e next_state(input tap_state_e s, input logic tms);
        tap_state_e n;
        n = s;
        unique case (s)
            TLR:      n = tms ? TLR    : RTI;
            RTI:      n = tms ? SEL_DR : RTI;
            SEL_DR:   n = tms ? SEL_IR : CAP_DR;
            CAP_DR:   n = tms ? EX1_DR : SHIFT_DR;
            SHIFT_DR: n = tms ? EX1_DR : SHIFT_DR;
            EX1_DR:   n = tms ? UPD_DR : PAUSE_DR;
            PAUSE_DR: n = tms ? EX2_DR : PAUSE_DR;
            EX2_DR:   n = tms ? UPD_DR : SHIFT_DR;
            UPD_DR:   n = tms ? SEL_DR : RTI;
            SEL_IR:   n = tms ? TLR    : CAP_IR;
            CAP_IR:   n = tms ? EX1_IR : SHIFT_IR;
            SHIFT_IR: n = tms ? EX1_IR : SHIFT_IR;
            EX1_IR:   n = tms ? UPD_IR : PAUSE_IR;
            PAUSE_IR: n = tms ? EX2_IR : PAUSE_IR;
            EX2_IR:   n = tms ? UPD_IR : SHIFT_IR;
            UPD_IR:   n = tms ? SEL_DR : RTI;
        endcase
        return n;
    endfunction

    // Edges of the synchronised test clock
    assign rise = q.sync.tck && !q.tck_prev;
    assign fall = !q.sync.tck && q.tck_prev;

    always_comb begin
        d          = q;
        push       = 1'b0;
        O_TX_READY = 1'b0;
        d.meta     = '{tck: I_TCK, tms: I_TMS, tdi: I_TDI};
        d.sync     = q.meta;
        d.tck_prev = q.sync.tck;
        if (rise) begin
            d.state = next_state(q.state, q.sync.tms);
            if (q.state == TLR) begin
                d.ir   = IR_RESET;
                d.drop = 1'b0;
            end
            if (q.state == CAP_DR) begin
                d.dr       = I_TX_VALID ? I_TX_DATA : DR_IDLE;
                O_TX_READY = 1'b1;
            end
            if (q.state == SHIFT_DR) begin
                d.dr = {q.sync.tdi, q.dr[DATA_W-1:1]};
            end
            if (q.state == UPD_DR) begin
                push = fifo_ready;
                if (!fifo_ready) begin
                    d.drop = 1'b1;
                end
            end
            if (q.state == CAP_IR) begin
                d.ir_sh = IR_CAPTURE;
            end
            if (q.state == SHIFT_IR) begin
                d.ir_sh = {q.sync.tdi, q.ir_sh[IR_W-1:1]};
            end
            if (q.state == UPD_IR) begin
                d.ir = q.ir_sh;
            end
        end
        // Output bit and its enable move on the falling edge
        if (fall) begin
            d.tdo    = (q.state == SHIFT_IR) ? q.ir_sh[0] : q.dr[0];
            d.tdo_oe = (q.state == SHIFT_IR) || (q.state == SHIFT_DR);
        end
    end

    always_ff @(posedge I_MCLK or negedge I_NRST) begin
        if (!I_NRST) begin
            q          <= '0;
            q.state    <= TLR;
            q.ir       <= IR_RESET;
            q.tdo      <= TDO_IDLE;
            q.tdo_oe   <= 1'b0;
        end else begin
            q <= d;
        end
    end

    tap_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .i_clk       (I_MCLK),
        .i_nrst      (I_NRST),
        .i_in_valid  (push),
        .i_in_data   (q.dr),
        .o_in_ready  (fifo_ready),
        .o_out_valid (rx_out.valid),
        .o_out_data  (rx_out.data),
        .i_out_ready (I_RX_READY)
    );

    assign O_TDO       = q.tdo;
    assign O_TDO_OE    = q.tdo_oe;
    assign O_IR        = q.ir;
    assign O_TAP_STATE = q.state;
    assign O_RX_VALID  = rx_out.valid;
    assign O_RX_DATA   = rx_out.data;
    assign O_RX_SPACE  = fifo_ready;
    assign O_RX_DROP   = q.drop;

endmodule

// file: include/tap_pkg.sv
// Shared constants, state codes and carriers for the test access port.
// Assumes one system clock domain; the test pins arrive asynchronously.
package tap_pkg;

    localparam int          DATA_W      = 8;
    localparam int          FIFO_DEPTH  = 8;
    localparam int          IR_W        = 4;
    localparam logic [3:0]  IR_CAPTURE  = 4'h1;
    localparam logic [3:0]  IR_RESET    = 4'h1;
    localparam logic [7:0]  DR_IDLE     = 8'h00;
    localparam logic        TDO_IDLE    = 1'b0;

    typedef enum logic [3:0] {
        TLR      = 4'h0,
        RTI      = 4'h1,
        SEL_DR   = 4'h3,
        CAP_DR   = 4'h2,
        SHIFT_DR = 4'h6,
        EX1_DR   = 4'h7,
        PAUSE_DR = 4'h5,
        EX2_DR   = 4'h4,
        UPD_DR   = 4'hC,
        SEL_IR   = 4'hD,
        CAP_IR   = 4'hF,
        SHIFT_IR = 4'hE,
        EX1_IR   = 4'hA,
        PAUSE_IR = 4'hB,
        EX2_IR   = 4'h9,
        UPD_IR   = 4'h8
    } tap_state_e;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } pins_s;

    typedef struct packed {
        logic              valid;
        logic [DATA_W-1:0] data;
    } word_s;

endpackage

// file: rtl/tap_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes writer and reader share the system clock.
`timescale 1ns/1ps
module tap_fifo import tap_pkg::*; #(
    parameter int WIDTH = DATA_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    input  logic             i_clk,
    input  logic             i_nrst,
    input  logic             i_in_valid,
    input  logic [WIDTH-1:0] i_in_data,
    output logic             o_in_ready,
    output logic             o_out_valid,
    output logic [WIDTH-1:0] o_out_data,
    input  logic             i_out_ready
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0]                 wr;
        logic [AW:0]                 rd;
    } fifo_s;

    fifo_s q;
    fifo_s d;
    logic  full;
    logic  empty;
    logic  do_wr;
    logic  do_rd;

    assign full        = (q.wr[AW] != q.rd[AW]) && (q.wr[AW-1:0] == q.rd[AW-1:0]);
    assign empty       = (q.wr == q.rd);
    assign o_in_ready  = !full;
    assign o_out_valid = !empty;
    assign o_out_data  = q.mem[q.rd[AW-1:0]];
    assign do_wr       = i_in_valid && !full;
    assign do_rd       = i_out_ready && !empty;

    always_comb begin
        d = q;
        if (do_wr) begin
            d.mem[q.wr[AW-1:0]] = i_in_data;
            d.wr                = q.wr + 1'b1;
        end
        if (do_rd) begin
            d.rd = q.rd + 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule

// file: verification/tap_port_props.sv
// Pin-level checker for the test port.
// Bound onto tap_port by the bench.
`timescale 1ns/1ps
module tap_port_props import tap_pkg::*; (
    input wire logic       I_MCLK,
    input wire logic       I_NRST,
    input wire logic       I_TCK,
    input wire logic       I_TMS,
    input wire logic       O_TDO,
    input wire logic       O_TDO_OE,
    input wire logic [3:0] O_TAP_STATE,
    input wire logic       O_TX_READY
);
    wire shift = O_TAP_STATE inside {SHIFT_DR, SHIFT_IR};
    default clocking @(posedge I_MCLK); endclocking
    default disable iff (!I_NRST);
    property p_tdo_fall; ($changed(O_TDO) || $changed(O_TDO_OE)) |-> !I_TCK; endproperty
    a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved");
    property p_st_rise; $changed(O_TAP_STATE) |-> I_TCK; endproperty
    a_st_rise: assert property (p_st_rise) else $error("state moved");
    property p_oe_on; $rose(O_TDO_OE) |-> shift; endproperty
    a_oe_on: assert property (p_oe_on) else $error("oe on");
    property p_oe_off; O_TDO_OE && !shift |-> ##[1:16] !O_TDO_OE; endproperty
    a_oe_off: assert property (p_oe_off) else $error("oe off");
    property p_oe_rst; disable iff (1'b0) !I_NRST |-> !O_TDO_OE; endproperty
    a_oe_rst: assert property (p_oe_rst) else $error("oe in reset");
    property p_tlr_exit; $changed(O_TAP_STATE) && $past(O_TAP_STATE) == TLR |-> !I_TMS && O_TAP_STATE == RTI;
    endproperty
    a_tlr_exit: assert property (p_tlr_exit) else $error("tlr exit");
    property p_tx_cap; O_TX_READY |-> O_TAP_STATE == CAP_DR ##1 O_TAP_STATE == SHIFT_DR; endproperty
    a_tx_cap: assert property (p_tx_cap) else $error("capture");
    c_ir: cover property (O_TAP_STATE == SHIFT_IR);
    c_tx: cover property (O_TX_READY);
    c_oe: cover property ($fell(O_TDO_OE));
endmodule

// file: verification/tap_ctl.sv
// Test controller model driving TCK, TMS, TDI.
// Assumes the bench applies the pin pulls.
`timescale 1ns/1ps
module tap_ctl (
    output logic      o_tck,
    output logic      o_tms,
    output logic      o_tdi,
    output logic      o_drv,
    input  wire logic i_tdo
);
    initial begin
        o_tck = 0;
        o_drv = 0;
    end
    // One 125 ns TCK period, low at rest, edges clear of I_MCLK rising edges
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        o_drv = 1;
        o_tms = tms;
        o_tdi = tdi;
        #60 o_tck = 1;
        tdo = i_tdo;
        #65 o_tck = 0;
    endtask
endmodule

// file: verification/tap_port_tb.sv
// Bench: scans, FIFO fill and drain, resets.
// Assumes checker and controller model.
`timescale 1ns/1ps
module tap_port_tb import tap_pkg::*;;
    logic       mclk, nrst, tx_valid, rx_ready, tdo, tdo_oe, tx_ready, rx_valid, rx_space, rx_drop;
    logic       m_tck, m_tms, m_tdi, m_drv, o;
    logic [3:0] ir, st;
    logic [7:0] tx_data, rx_data, d, q;
    logic [7:0] exp_q[$];
    int         errors, checks_done, cyc, tx_seen;
    wire        tck = m_drv ? m_tck : 1'b0;
    wire        tms = m_drv ? m_tms : 1'b1;
    wire        tdi = m_drv ? m_tdi : 1'b1;
    wire        tdo_w = tdo_oe ? tdo : 1'bz;
    tap_ctl i_tap_ctl (.o_tck(m_tck), .o_tms(m_tms), .o_tdi(m_tdi), .o_drv(m_drv), .i_tdo(tdo_w));
    tap_port i_tap_port (.I_MCLK(mclk), .I_NRST(nrst), .I_TCK(tck), .I_TMS(tms), .I_TDI(tdi), .O_TDO(tdo),
        .O_TDO_OE(tdo_oe), .O_IR(ir), .O_TAP_STATE(st), .I_TX_VALID(tx_valid), .I_TX_DATA(tx_data),
        .O_TX_READY(tx_ready), .O_RX_VALID(rx_valid), .O_RX_DATA(rx_data), .I_RX_READY(rx_ready),
        .O_RX_SPACE(rx_space), .O_RX_DROP(rx_drop));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("errors=%0d checks=%0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // DR or IR scan of n bits of d from idle, back to idle
    task automatic scan(input bit irs, input int n, output logic [7:0] r);
        logic b;
        r = 8'h00;
        i_tap_ctl.step(1, 1, b);
        if (irs) i_tap_ctl.step(1, 1, b);
        i_tap_ctl.step(0, 1, b);
        i_tap_ctl.step(0, 1, b);
        for (int i = 0; i < n; i++) begin
            i_tap_ctl.step(i == n - 1, d[i], b);
            r[i] = b;
        end
        i_tap_ctl.step(1, 1, b);
        i_tap_ctl.step(0, 1, b);
    endtask
    initial begin
        mclk = 0;
        forever #2.5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 8000) begin
            errors++;
            close_out();
        end
    end
    // Capture pulses, counted where they are settled
    always @(negedge mclk) begin
        if (tx_ready === 1'b1) begin
            tx_seen++;
        end
    end
    initial begin
        nrst = 0;
        tx_valid = 0;
        tx_data = 8'h00;
        rx_ready = 0;
        void'($urandom(32'h0FD6));
        repeat (3) @(posedge mclk);
        @(negedge mclk) nrst = 1;
        chk({tdo_oe, 3'h0, st}, {1'b0, 3'h0, TLR});
        i_tap_ctl.step(0, 1, o);
        chk({ir, st}, {IR_RESET, RTI});
        for (int k = 0; k < 9; k++) begin
            tx_valid = 1;
            tx_data = 8'($urandom);
            d = 8'($urandom);
            scan(0, 8, q);
            chk(q, tx_data);
            if (k < 8) exp_q.push_back(d);
        end
        chk({6'h00, rx_drop, rx_space}, 8'h02);
        while (exp_q.size() > 0) begin
            @(negedge mclk);
            rx_ready = 1'($urandom);
            if (rx_ready && rx_valid) chk(rx_data, exp_q.pop_front());
        end
        @(negedge mclk) rx_ready = 0;
        chk({7'h00, rx_valid}, 8'h00);
        d = 8'($urandom);
        scan(1, 4, q);
        chk({q[3:0], ir}, {IR_CAPTURE, d[3:0]});
        i_tap_ctl.step(1, 1, o);
        i_tap_ctl.step(1, 1, o);
        i_tap_ctl.step(0, 1, o);
        i_tap_ctl.step(0, 1, o);
        repeat (5) i_tap_ctl.step(1, 1, o);
        chk({st, 4'h0}, {TLR, 4'h0});
        i_tap_ctl.step(0, 1, o);
        chk({ir, 3'h0, rx_drop}, {IR_RESET, 4'h0});
        i_tap_ctl.step(1, 1, o);
        i_tap_ctl.step(0, 1, o);
        i_tap_ctl.step(0, 1, o);
        repeat (6) @(negedge mclk);
        chk({7'h00, tdo_oe}, 8'h01);
        nrst = 0;
        @(negedge mclk);
        chk({tdo_oe, 3'h0, st}, {1'b0, 3'h0, TLR});
        nrst = 1;
        repeat (2) @(negedge mclk);
        chk({tdo_oe, 3'h0, st}, {1'b0, 3'h0, TLR});
        i_tap_ctl.step(0, 1, o);
        chk({ir, st}, {IR_RESET, RTI});
        chk(8'(tx_seen), 8'h0A);
        close_out();
    end
endmodule
bind tap_port tap_port_props i_tap_port_props (.I_MCLK(I_MCLK), .I_NRST(I_NRST), .I_TCK(I_TCK), .I_TMS(I_TMS),
    .O_TDO(O_TDO), .O_TDO_OE(O_TDO_OE), .O_TAP_STATE(O_TAP_STATE), .O_TX_READY(O_TX_READY));
